// [rtl/slr_fifo.sv]
// first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module slr_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0] wr_r;
	logic [AW:0] rd_r;
	wire full_w = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
	wire empty_w = (wr_r == rd_r);
	wire push_w = in_valid_i && !full_w;
	wire pop_w = out_ready_i && !empty_w;
	assign in_ready_o = !full_w;
	assign out_valid_o = !empty_w;
	assign out_data_o = mem_r[rd_r[AW-1:0]];

	always_ff @(posedge ref_clk_i) begin
		if (push_w) begin
			mem_r[wr_r[AW-1:0]] <= in_data_i;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_r <= '0;
			rd_r <= '0;
		end else begin
			if (push_w) begin
				wr_r <= wr_r + 1'b1;
			end
			if (pop_w) begin
				rd_r <= rd_r + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// [rtl/slr_params.svh]
// constants shared by the serial receiver files
`ifndef SLR_PARAMS_SVH
`define SLR_PARAMS_SVH

`define SLR_CLK_HZ 10000000
`define SLR_BAUD 9600
`define SLR_HALF_BIT_US 52
`define SLR_WINDOW_US 924
`define SLR_MHZ 1000000
`define SLR_BIT_CYC (`SLR_CLK_HZ / `SLR_BAUD)
`define SLR_HALF_CYC ((`SLR_HALF_BIT_US * `SLR_CLK_HZ + `SLR_MHZ - 1) / `SLR_MHZ)
`define SLR_WINDOW_CYC (`SLR_WINDOW_US * (`SLR_CLK_HZ / `SLR_MHZ))
`define SLR_DATA_BITS 8
`define SLR_TICKS 9
`define SLR_TICK_W 4
`define SLR_BIT_W 11
`define SLR_WIN_W 14
`define SLR_FIFO_DEPTH 16
`define SLR_CTL_SEL_BIT 0
`define SLR_CTL_EN_BIT 1
`define SLR_GRP_CTL 1'h0
`define SLR_GRP_DATA 1'h1

`endif

// [rtl/slr_pkg.sv]
// types shared by the serial receiver files
package slr_pkg;
	typedef enum logic [2:0] {ST_IDLE, ST_DELAY, ST_SHIFT, ST_TAIL, ST_PUSH} slr_state_t;
	typedef logic [7:0] slr_byte_t;
endpackage

// [rtl/slr_shift.sv]
// serial to parallel shifter sampling on rising bit clock edges
`timescale 1ns/1ps
`default_nettype none
`include "slr_params.svh"
module slr_shift (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// serial side
	input wire logic bit_clk_i,
	input wire logic select_n_i,
	input wire logic serial_i,
	input wire logic frame_done_i,
	// parallel side
	output slr_pkg::slr_byte_t byte_o
);
	logic [`SLR_TICKS-1:0] shreg_r;
	logic bit_clk_q_r;
	wire rise_w = bit_clk_i && !bit_clk_q_r;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shreg_r <= '0;
			bit_clk_q_r <= 1'h0;
			byte_o <= '0;
		end else begin
			bit_clk_q_r <= bit_clk_i;
			if (rise_w && !select_n_i) begin
				shreg_r <= {serial_i, shreg_r[`SLR_TICKS-1:1]};
			end
			if (frame_done_i) begin
				byte_o <= shreg_r[`SLR_TICKS-1:1];
			end
		end
	end
endmodule
`default_nettype wire

// [rtl/slr_top.sv]
// receive-only serial front end steering byte pairs to display latches
`timescale 1ns/1ps
`default_nettype none
`include "slr_params.svh"
module slr_top #(
	parameter int WINDOW_CYC = `SLR_WINDOW_CYC
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// serial line from host
	input wire logic host_serial_out_i,
	// display side flow control
	input wire logic display_ready_i,
	// display outputs
	output logic register_select_out_o,
	output logic display_enable_out_o,
	output logic [`SLR_DATA_BITS-1:0] display_data_out_o,
	// frame status
	output logic frame_window_o,
	output logic shift_select_n_o
);
	localparam int HALF_CYC = `SLR_HALF_CYC;
	localparam int BIT_CYC = `SLR_BIT_CYC;
	localparam logic [`SLR_BIT_W-1:0] HALF_LAST = `SLR_BIT_W'(HALF_CYC - 1);
	localparam logic [`SLR_BIT_W-1:0] BIT_LAST = `SLR_BIT_W'(BIT_CYC - 1);
	localparam logic [`SLR_BIT_W-1:0] BIT_MID = `SLR_BIT_W'(BIT_CYC / 2);
	localparam logic [`SLR_WIN_W-1:0] WIN_LAST = `SLR_WIN_W'(WINDOW_CYC - 1);
	localparam logic [`SLR_TICK_W-1:0] TICKS = `SLR_TICK_W'(`SLR_TICKS);

	slr_pkg::slr_state_t state_r;
	slr_pkg::slr_state_t state_nxt;

	// line sampling and start edge detector
	logic line_prev_r;
	logic start_pulse_r;
	logic frame_window_r;
	logic [`SLR_WIN_W-1:0] win_cnt_r;
	logic [`SLR_BIT_W-1:0] bit_cnt_r;
	logic [`SLR_TICK_W-1:0] tick_cnt_r;
	logic bit_clk_r;
	logic shift_select_n_r;
	logic grp_r;
	logic frame_grp_r;
	logic pend_r;
	slr_pkg::slr_byte_t rx_byte_w;

	// output holding latches
	logic sel_out_r;
	logic en_r;
	logic [`SLR_DATA_BITS-1:0] data_r;

	// decode
	wire idle_w = (state_r == slr_pkg::ST_IDLE);
	wire counting_w = (state_r == slr_pkg::ST_DELAY) || (state_r == slr_pkg::ST_SHIFT);
	wire fall_w = idle_w && !pend_r && line_prev_r && !host_serial_out_i;
	wire half_tick_w = (state_r == slr_pkg::ST_DELAY) && (bit_cnt_r == HALF_LAST);
	wire bit_tick_w = (state_r == slr_pkg::ST_SHIFT) && (bit_cnt_r == BIT_LAST);
	wire tick_w = half_tick_w || bit_tick_w;
	wire last_tick_w = tick_w && (tick_cnt_r == TICKS - 1'b1);
	wire win_end_w = frame_window_r && (win_cnt_r == WIN_LAST);
	wire frame_done_w = win_end_w;
	wire sel_release_w = (state_r == slr_pkg::ST_TAIL) && bit_clk_r;

	// fifo hookup
	wire fifo_in_ready_w;
	wire fifo_out_valid_w;
	wire [`SLR_DATA_BITS:0] fifo_out_data_w;
	wire pop_w = fifo_out_valid_w && display_ready_i;
	wire pop_grp_w = fifo_out_data_w[`SLR_DATA_BITS];
	wire [`SLR_DATA_BITS-1:0] pop_byte_w = fifo_out_data_w[`SLR_DATA_BITS-1:0];
	wire push_w = pend_r && fifo_in_ready_w;
	wire steer_ctl_w = pop_w && (pop_grp_w == `SLR_GRP_CTL);
	wire steer_data_w = pop_w && (pop_grp_w == `SLR_GRP_DATA);

	// sequencer
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			slr_pkg::ST_IDLE: begin
				if (start_pulse_r) begin
					state_nxt = slr_pkg::ST_DELAY;
				end
			end
			slr_pkg::ST_DELAY: begin
				if (win_end_w) begin
					state_nxt = slr_pkg::ST_PUSH;
				end else if (half_tick_w) begin
					state_nxt = slr_pkg::ST_SHIFT;
				end
			end
			slr_pkg::ST_SHIFT: begin
				if (win_end_w) begin
					state_nxt = slr_pkg::ST_PUSH;
				end else if (last_tick_w) begin
					state_nxt = slr_pkg::ST_TAIL;
				end
			end
			slr_pkg::ST_TAIL: begin
				if (win_end_w) begin
					state_nxt = slr_pkg::ST_PUSH;
				end
			end
			slr_pkg::ST_PUSH: begin
				if (push_w) begin
					state_nxt = slr_pkg::ST_IDLE;
				end
			end
			default: begin
				state_nxt = slr_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= slr_pkg::ST_IDLE;
			line_prev_r <= 1'h1;
			start_pulse_r <= 1'h0;
		end else begin
			state_r <= state_nxt;
			line_prev_r <= host_serial_out_i;
			start_pulse_r <= fall_w && !start_pulse_r;
		end
	end

	// frame window latch and its timer
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			frame_window_r <= 1'h0;
			win_cnt_r <= '0;
		end else if (start_pulse_r) begin
			frame_window_r <= 1'h1;
			win_cnt_r <= '0;
		end else if (win_end_w) begin
			frame_window_r <= 1'h0;
			win_cnt_r <= '0;
		end else if (frame_window_r) begin
			win_cnt_r <= win_cnt_r + 1'b1;
		end
	end

	// gated bit clock counter
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bit_cnt_r <= '0;
			tick_cnt_r <= '0;
		end else if (!counting_w) begin
			bit_cnt_r <= '0;
			if (idle_w) begin
				tick_cnt_r <= '0;
			end
		end else if (tick_w) begin
			bit_cnt_r <= '0;
			tick_cnt_r <= tick_cnt_r + 1'b1;
		end else begin
			bit_cnt_r <= bit_cnt_r + 1'b1;
		end
	end

	// bit clock level, idle low, high for first half of each bit, one cycle only after the last tick
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bit_clk_r <= 1'h0;
		end else if (tick_w) begin
			bit_clk_r <= 1'h1;
		end else if (!counting_w || bit_cnt_r == BIT_MID) begin
			bit_clk_r <= 1'h0;
		end
	end

	// shift select, active low across start and data bits
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shift_select_n_r <= 1'h1;
		end else if (start_pulse_r) begin
			shift_select_n_r <= 1'h0;
		end else if (sel_release_w || win_end_w) begin
			shift_select_n_r <= 1'h1;
		end
	end

	// divide-by-two group selector and pending byte
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			grp_r <= `SLR_GRP_CTL;
			frame_grp_r <= `SLR_GRP_CTL;
			pend_r <= 1'h0;
		end else begin
			if (start_pulse_r) begin
				frame_grp_r <= grp_r;
				grp_r <= !grp_r;
			end
			if (frame_done_w) begin
				pend_r <= 1'h1;
			end else if (push_w) begin
				pend_r <= 1'h0;
			end
		end
	end

	slr_shift u_shift (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.bit_clk_i(bit_clk_r),
		.select_n_i(shift_select_n_r),
		.serial_i(host_serial_out_i),
		.frame_done_i(frame_done_w),
		.byte_o(rx_byte_w)
	);

	slr_fifo #(
		.WIDTH(`SLR_DATA_BITS + 1),
		.DEPTH(`SLR_FIFO_DEPTH)
	) u_fifo (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(pend_r),
		.in_ready_o(fifo_in_ready_w),
		.in_data_i({frame_grp_r, rx_byte_w}),
		.out_valid_o(fifo_out_valid_w),
		.out_ready_i(display_ready_i),
		.out_data_o(fifo_out_data_w)
	);

	// holding latches toward the display
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sel_out_r <= 1'h0;
			en_r <= 1'h0;
			data_r <= '0;
		end else if (steer_ctl_w) begin
			sel_out_r <= pop_byte_w[`SLR_CTL_SEL_BIT];
			en_r <= pop_byte_w[`SLR_CTL_EN_BIT];
		end else if (steer_data_w) begin
			data_r <= pop_byte_w;
		end
	end

	assign register_select_out_o = sel_out_r;
	assign display_enable_out_o = en_r;
	assign display_data_out_o = data_r;
	assign frame_window_o = frame_window_r;
	assign shift_select_n_o = shift_select_n_r;

	// checks
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_edge_pulse;
		start_pulse_r |=> !start_pulse_r && frame_window_r;
	endproperty
	a_edge_pulse: assert property (p_edge_pulse) else $error("edge pulse not single");

	property p_fall_cause;
		start_pulse_r |-> $past(line_prev_r) && !$past(host_serial_out_i);
	endproperty
	a_fall_cause: assert property (p_fall_cause) else $error("start without fall");

	property p_window_len;
		$fell(frame_window_r) |-> $past(win_cnt_r) == WIN_LAST;
	endproperty
	a_window_len: assert property (p_window_len) else $error("window length wrong");

	property p_half_delay;
		$rose(bit_clk_r) && tick_cnt_r == `SLR_TICK_W'(1) |-> win_cnt_r == `SLR_WIN_W'(HALF_CYC);
	endproperty
	a_half_delay: assert property (p_half_delay) else $error("half bit delay wrong");

	property p_gate;
		idle_w |=> bit_cnt_r == '0 && !bit_clk_r;
	endproperty
	a_gate: assert property (p_gate) else $error("bit counter ran while idle");

	property p_select_end;
		$rose(shift_select_n_r) && !$past(win_end_w) |-> tick_cnt_r == TICKS;
	endproperty
	a_select_end: assert property (p_select_end) else $error("select released early");

	property p_bit_period;
		bit_tick_w |-> !bit_clk_r && !$past(bit_clk_r) ##1 bit_clk_r;
	endproperty
	a_bit_period: assert property (p_bit_period) else $error("bit clock shape wrong");

	property p_toggle;
		start_pulse_r |=> grp_r != $past(grp_r) && frame_grp_r == $past(grp_r);
	endproperty
	a_toggle: assert property (p_toggle) else $error("group did not toggle");

	property p_steer_ctl;
		steer_ctl_w |=> sel_out_r == $past(pop_byte_w[`SLR_CTL_SEL_BIT]) && $stable(data_r);
	endproperty
	a_steer_ctl: assert property (p_steer_ctl) else $error("control byte misrouted");

	property p_steer_data;
		steer_data_w |=> data_r == $past(pop_byte_w) && $stable(sel_out_r) && $stable(en_r);
	endproperty
	a_steer_data: assert property (p_steer_data) else $error("data byte misrouted");

	property p_hold;
		!pop_w |=> $stable(data_r) && $stable(sel_out_r) && $stable(en_r);
	endproperty
	a_hold: assert property (p_hold) else $error("latch changed without byte");
endmodule
`default_nettype wire

// [sim/slr_host_model.sv]
// host transmitter model driving the serial line
`timescale 1ns/1ps
`default_nettype none
`include "slr_params.svh"
module slr_host_model (
	// clock
	input wire logic ref_clk_i,
	// request from bench
	input wire logic go_i,
	input wire logic [7:0] byte_i,
	// serial line
	output logic line_o,
	output logic busy_o
);
	logic [9:0] frame;
	initial begin
		line_o = 1'h1;
		busy_o = 1'h0;
	end
	task automatic send(input logic [7:0] b);
		frame = {1'h1, b, 1'h0};
		busy_o = 1'h1;
		for (int i = 0; i < 10; i++) begin
			line_o = frame[i];
			repeat (`SLR_BIT_CYC) @(negedge ref_clk_i);
		end
		line_o = 1'h1;
		busy_o = 1'h0;
	endtask
	always @(negedge ref_clk_i) begin
		if (go_i && !busy_o) begin
			send(byte_i);
		end
	end
endmodule
`default_nettype wire

// [sim/testbench.sv]
// testbench for the serial to display receiver
`timescale 1ns/1ps
`default_nettype none
`include "slr_params.svh"
`define SLR_CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
	$display("ERROR t=%0t got %h want %h", $time, (a), (b)); end end
module testbench;
	logic ref_clk_i;
	logic rst_n_i;
	logic display_ready_i;
	logic go;
	logic [7:0] tx_byte;
	logic line;
	logic busy;
	logic regsel;
	logic en;
	logic [7:0] data;
	logic win;
	logic sel_n;
	int error_cnt;
	int n_compared;
	slr_host_model host (
		.ref_clk_i(ref_clk_i),
		.go_i(go),
		.byte_i(tx_byte),
		.line_o(line),
		.busy_o(busy)
	);
	slr_top #(.WINDOW_CYC(`SLR_WINDOW_CYC)) dut (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.host_serial_out_i(line),
		.display_ready_i(display_ready_i),
		.register_select_out_o(regsel),
		.display_enable_out_o(en),
		.display_data_out_o(data),
		.frame_window_o(win),
		.shift_select_n_o(sel_n)
	);
	initial begin
		ref_clk_i = 1'h0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end
	task automatic report_and_stop();
		$display("errors %0d compared %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// one frame with window and select timing checks
	task automatic frame(input logic [7:0] b);
		int n;
		int sel_at;
		n = 0;
		sel_at = 0;
		tx_byte <= b;
		go <= 1'h1;
		@(negedge line);
		go <= 1'h0;
		@(posedge ref_clk_i);
		#1 `SLR_CHK(win, 1'h0)
		@(posedge ref_clk_i);
		#1 `SLR_CHK(win, 1'h1)
		`SLR_CHK(sel_n, 1'h0)
		while (win === 1'h1 && n < 20000) begin
			@(posedge ref_clk_i);
			#1 n++;
			if (sel_n === 1'h1 && sel_at == 0) sel_at = n;
		end
		`SLR_CHK(n, `SLR_WINDOW_CYC)
		`SLR_CHK(sel_at >= 8840 && sel_at <= 8860, 1'h1)
		n = 0;
		while (busy === 1'h1 && n < 3000) begin
			@(negedge ref_clk_i);
			n++;
		end
		`SLR_CHK(busy, 1'h0)
		repeat (4) @(negedge ref_clk_i);
	endtask
	task automatic t_reset();
		repeat (20) @(negedge ref_clk_i);
		`SLR_CHK({regsel, en, data, win, sel_n}, 12'h001)
	endtask
	task automatic t_pair();
		frame(8'h03);
		`SLR_CHK({regsel, en, data}, 10'h300)
		frame(8'ha5);
		`SLR_CHK({regsel, en, data}, 10'h3a5)
	endtask
	task automatic t_edges();
		frame(8'h01);
		`SLR_CHK({regsel, en, data}, 10'h2a5)
		frame(8'h80);
		`SLR_CHK({regsel, en, data}, 10'h280)
	endtask
	task automatic t_stall();
		display_ready_i <= 1'h0;
		frame(8'h02);
		frame(8'h5a);
		`SLR_CHK({regsel, en, data}, 10'h280)
		display_ready_i <= 1'h1;
		repeat (4) @(negedge ref_clk_i);
		`SLR_CHK({regsel, en, data}, 10'h15a)
	endtask
	initial begin
		error_cnt = 0;
		n_compared = 0;
		rst_n_i = 1'h0;
		display_ready_i = 1'h1;
		go = 1'h0;
		tx_byte = 8'h00;
		repeat (12) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		rst_n_i = 1'h1;
		t_reset();
		t_pair();
		t_edges();
		t_stall();
		report_and_stop();
	end
	initial begin
		repeat (80000) @(posedge ref_clk_i);
		error_cnt++;
		$display("ERROR t=%0t watchdog expired", $time);
		report_and_stop();
	end
endmodule
`default_nettype wire
